// file: rtl/tcc_defs.vh
// shared constants for the timer counter and capture block
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
// register addresses on the 8-bit register port
`define TCC_A_CNT_LO     4'h0
`define TCC_A_CNT_HI     4'h1
`define TCC_A_CAP_LO     4'h2
`define TCC_A_CAP_HI     4'h3
`define TCC_A_CTRL_A     4'h4
`define TCC_A_CTRL_B     4'h5
`define TCC_A_FLAGS      4'h6
`define TCC_A_MASK       4'h7
`define TCC_A_CMP_CTRL   4'h8
// control a: mode low bits
`define TCC_CA_WGM_LO    1:0
// control b fields
`define TCC_CB_CS        2:0
`define TCC_CB_WGM_HI    4:3
`define TCC_CB_EDGE      6
`define TCC_CB_FILT      7
// flag and mask bit positions
`define TCC_F_OVF        0
`define TCC_F_CAP        5
// comparator control bit
`define TCC_CC_SEL       2
// counter extremes
`define TCC_MAX          16'hffff
`define TCC_ZERO         16'h0000
// filter sample count
`define TCC_FILT_N       3'h4
// reset values
`define TCC_RST_8        8'h00
`define TCC_RST_16       16'h0000
// modes that take top from the capture register
`define TCC_M_PFC_CAP    4'h8
`define TCC_M_PC_CAP     4'ha
`define TCC_M_CTC_CAP    4'hc
`define TCC_M_FAST_CAP   4'he
// modes counting both ways
`define TCC_M_DUAL_A     4'h1
`define TCC_M_DUAL_D     4'hb
// clock select codes with a fixed meaning
`define TCC_CS_STOP      3'h0
`define TCC_CS_SYS       3'h1
`define TCC_CS_EXT_FALL  3'h6
`define TCC_CS_EXT_RISE  3'h7
// fixed tops of the 8, 9 and 10-bit modes
`define TCC_TOP_8        16'h00ff
`define TCC_TOP_9        16'h01ff
`define TCC_TOP_10       16'h03ff
// other decoded modes
`define TCC_M_DUAL_9     4'h2
`define TCC_M_DUAL_10    4'h3
`define TCC_M_FAST_8     4'h5
`define TCC_M_FAST_9     4'h6
`define TCC_M_FAST_10    4'h7
`define TCC_M_PFC_OTHER  4'h9
// pin bus width and bit positions
`define TCC_N_PINS       3
`define TCC_P_CAP        0
`define TCC_P_CMP        1
`define TCC_P_EXT        2
`endif

// file: rtl/tcc_sync_edge.v
// two-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
module tcc_sync_edge (
	input  wire       clk,
	input  wire       rst,
	input  wire       async_in,
	output wire       sync_out
);
	reg sync1_ff;
	reg sync2_ff;

	// first stage read only by the second
	always @(posedge clk) begin
		if (rst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= async_in;
			sync2_ff <= sync1_ff;
		end
	end

	assign sync_out = sync2_ff;
endmodule
`default_nettype wire

// file: rtl/tcc_noise_filter.v
// four-sample agreement noise filter
`timescale 1ns/100ps
`include "tcc_defs.vh"
`default_nettype none
module tcc_noise_filter (
	input  wire       clk,
	input  wire       rst,
	input  wire       sample_in,
	output wire       filt_out
);
	reg       out_ff;
	reg [2:0] agree_ff;
	reg       nxt_out;
	reg [2:0] nxt_agree;

	// count samples differing from output, flip on the fourth
	always @* begin
		nxt_out   = out_ff;
		nxt_agree = 3'h0;
		if (sample_in != out_ff) begin
			nxt_agree = agree_ff + 3'h1;
			if (nxt_agree == `TCC_FILT_N) begin
				nxt_out   = sample_in;
				nxt_agree = 3'h0;
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			out_ff   <= 1'b0;
			agree_ff <= 3'h0;
		end else begin
			out_ff   <= nxt_out;
			agree_ff <= nxt_agree;
		end
	end

	assign filt_out = out_ff;
endmodule
`default_nettype wire

// file: rtl/tcc_timer.v
// 16-bit timer counter unit with input capture
// Behaviour
// - each tick counts up, down or clears; top and bottom signalled
// - count seen as high and low byte locations
// - high byte access uses shared latch; low read loads latch
// - low byte write loads all 16 bits using latch as high
// - clock select zero gives no ticks
// - cpu access works with or without ticks
// - cpu write beats clear or count in same cycle
// - four-bit mode split across control b and control a
// - overflow flag set per mode, may request interrupt
// - selected edge copies count into capture register
// - capture flag set in the same cycle as copy
// - capture flag requests irq if enabled; cleared by ack or one-write
// - capture low read loads latch; high read returns latch
// - capture writable only in capture-top modes, high byte first
// - trigger from pin, or comparator when select bit set
// - source switch may capture; software clears flag after
// - both trigger inputs synchronised with same edge detector
// - filter changes only after four agreeing samples
// - filter enable in control b, four cycles delay, system clock
// - trigger inputs off in capture-top modes
// - new capture overwrites unread value
// - capture pin toggled by port output still captures
`timescale 1ns/100ps
`include "tcc_defs.vh"
`default_nettype none
module tcc_timer (
	input  wire       clk,
	input  wire       rst,
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       presc_tick,
	input  wire       ext_count_pin,
	input  wire       capture_pin,
	input  wire       comparator_output,
	input  wire       overflow_ack,
	input  wire       capture_ack,
	output wire       overflow_irq,
	output wire       capture_irq,
	output wire       count_top,
	output wire       count_bottom,
	output wire [15:0] timer_count
);
	reg [15:0] count_ff;
	reg [15:0] nxt_count;
	reg [15:0] capture_value_ff;
	reg [15:0] nxt_capture;
	reg [7:0]  latch_ff;
	reg [7:0]  nxt_latch;
	reg [7:0]  timer_control_a_ff;
	reg [7:0]  timer_control_b_ff;
	reg [7:0]  comparator_control_reg_ff;
	reg [7:0]  timer_irq_mask_reg_ff;
	reg        overflow_flag_ff;
	reg        capture_flag_ff;
	reg        down_ff;
	reg        nxt_down;
	reg        trig_prev_ff;
	reg        ext_prev_ff;
	reg        nxt_ovf;
	reg        nxt_cap_flag;
	reg [15:0] top_val;
	reg        count_up;
	reg        count_dn;
	reg        clear_cnt;
	reg        tick_sel;

	wire [3:0] waveform_mode_sel;
	wire       timer_tick;
	wire       cap_sync;
	wire       cmp_sync;
	wire       ext_sync;
	wire       trig_raw;
	wire       trig_filt;
	wire       trig_sel;
	wire       cap_top_mode;
	wire       cap_event;
	wire       cpu_cnt_wr;
	wire       wr_any;
	wire [2:0] pin_async;
	wire [2:0] pin_sync;

	genvar gi;

	// true for modes where the capture register sets top
	function cap_top;
		input [3:0] m;
		begin
			cap_top = (m == `TCC_M_PFC_CAP) || (m == `TCC_M_PC_CAP) ||
				(m == `TCC_M_CTC_CAP) || (m == `TCC_M_FAST_CAP);
		end
	endfunction

	// one edge detector for count pin and capture trigger
	function edge_hit;
		input cur;
		input prev;
		input rising;
		begin
			edge_hit = rising ? (cur && !prev) : (!cur && prev);
		end
	endfunction

	// true for modes that count up to top and back down to zero
	function dual_slope;
		input [3:0] m;
		begin
			dual_slope = (m == `TCC_M_DUAL_A) || (m == `TCC_M_DUAL_9) || (m == `TCC_M_DUAL_10) ||
				(m == `TCC_M_PFC_CAP) || (m == `TCC_M_PFC_OTHER) || (m == `TCC_M_PC_CAP) ||
				(m == `TCC_M_DUAL_D);
		end
	endfunction

	// mode assembled from both control registers
	assign waveform_mode_sel = {timer_control_b_ff[`TCC_CB_WGM_HI], timer_control_a_ff[`TCC_CA_WGM_LO]};
	assign cap_top_mode      = cap_top(waveform_mode_sel);

	// identical two-stage synchronisers for every pin input
	// pin bus order: capture pin, comparator output, count pin
	assign pin_async = {ext_count_pin, comparator_output, capture_pin};
	generate
		for (gi = 0; gi < `TCC_N_PINS; gi = gi + 1) begin : g_sync
			tcc_sync_edge u_sync (
				.clk      (clk),
				.rst      (rst),
				.async_in (pin_async[gi]),
				.sync_out (pin_sync[gi])
			);
		end
	endgenerate
	assign cap_sync = pin_sync[`TCC_P_CAP];
	assign cmp_sync = pin_sync[`TCC_P_CMP];
	assign ext_sync = pin_sync[`TCC_P_EXT];

	assign trig_raw = comparator_control_reg_ff[`TCC_CC_SEL] ? cmp_sync : cap_sync;

	// four-sample filter on the chosen trigger
	tcc_noise_filter u_filt (
		.clk       (clk),
		.rst       (rst),
		.sample_in (trig_raw),
		.filt_out  (trig_filt)
	);

	// filter enable bit selects filtered path
	assign trig_sel = timer_control_b_ff[`TCC_CB_FILT] ? trig_filt : trig_raw;

	// edge select; inputs gated off in capture-top modes
	assign cap_event = !cap_top_mode &&
		edge_hit(trig_sel, trig_prev_ff, timer_control_b_ff[`TCC_CB_EDGE]);

	// tick source per clock select, none when stopped
	always @* begin
		tick_sel = 1'b0;
		case (timer_control_b_ff[`TCC_CB_CS])
			`TCC_CS_STOP:     tick_sel = 1'b0;
			`TCC_CS_SYS:      tick_sel = 1'b1;
			`TCC_CS_EXT_FALL: tick_sel = edge_hit(ext_sync, ext_prev_ff, 1'b0);
			`TCC_CS_EXT_RISE: tick_sel = edge_hit(ext_sync, ext_prev_ff, 1'b1);
			default:          tick_sel = presc_tick;
		endcase
	end
	assign timer_tick = tick_sel;

	assign wr_any     = reg_wr;
	assign cpu_cnt_wr = wr_any && (reg_addr == `TCC_A_CNT_LO);

	// top value for the selected mode
	always @* begin
		top_val = `TCC_MAX;
		case (waveform_mode_sel)
			`TCC_M_DUAL_A, `TCC_M_FAST_8:   top_val = `TCC_TOP_8;
			`TCC_M_DUAL_9, `TCC_M_FAST_9:   top_val = `TCC_TOP_9;
			`TCC_M_DUAL_10, `TCC_M_FAST_10: top_val = `TCC_TOP_10;
			`TCC_M_PFC_CAP, `TCC_M_PC_CAP, `TCC_M_CTC_CAP, `TCC_M_FAST_CAP: top_val = capture_value_ff;
			default: top_val = `TCC_MAX;
		endcase
	end

	always @* begin
		count_up  = 1'b0;
		count_dn  = 1'b0;
		clear_cnt = 1'b0;
		nxt_down  = down_ff;
		nxt_ovf   = 1'b0;
		if (timer_tick) begin
			if (dual_slope(waveform_mode_sel)) begin
				// turn down at top, turn up at zero with overflow
				if (!down_ff && count_ff >= top_val) begin
					nxt_down = 1'b1;
					count_dn = 1'b1;
				end else if (down_ff && count_ff == `TCC_ZERO) begin
					nxt_down = 1'b0;
					count_up = 1'b1;
					nxt_ovf  = 1'b1;
				end else begin
					count_up = !down_ff;
					count_dn = down_ff;
				end
			end else begin
				// single slope: back to zero at top with overflow
				nxt_down = 1'b0;
				if (count_ff >= top_val) begin
					clear_cnt = 1'b1;
					nxt_ovf   = 1'b1;
				end else begin
					count_up = 1'b1;
				end
			end
		end
	end

	// cpu write has priority over tick actions
	always @* begin
		nxt_count = count_ff;
		if (cpu_cnt_wr) begin
			// full load with latched high byte
			nxt_count = {latch_ff, reg_wdata};
		end else if (clear_cnt) begin
			nxt_count = `TCC_ZERO;
		end else if (count_up) begin
			nxt_count = count_ff + 16'h0001;
		end else if (count_dn) begin
			nxt_count = count_ff - 16'h0001;
		end
	end

	// shared latch update on high writes and low reads
	always @* begin
		nxt_latch = latch_ff;
		if (wr_any && (reg_addr == `TCC_A_CNT_HI || reg_addr == `TCC_A_CAP_HI)) begin
			nxt_latch = reg_wdata;
		end else if (reg_rd && reg_addr == `TCC_A_CNT_LO) begin
			nxt_latch = count_ff[15:8];
		end else if (reg_rd && reg_addr == `TCC_A_CAP_LO) begin
			nxt_latch = capture_value_ff[15:8];
		end
	end

	always @* begin
		nxt_capture = capture_value_ff;
		if (cap_event) begin
			nxt_capture = count_ff;
		end else if (wr_any && reg_addr == `TCC_A_CAP_LO && cap_top_mode) begin
			nxt_capture = {latch_ff, reg_wdata};
		end
	end

	// flag set wins over ack or one-write clear
	always @* begin
		nxt_cap_flag = capture_flag_ff;
		if (capture_ack || (wr_any && reg_addr == `TCC_A_FLAGS && reg_wdata[`TCC_F_CAP])) begin
			nxt_cap_flag = 1'b0;
		end
		// flag set in the copy cycle
		if (cap_event) begin
			nxt_cap_flag = 1'b1;
		end
	end

	// state registers
	always @(posedge clk) begin
		if (rst) begin
			count_ff                  <= `TCC_RST_16;
			capture_value_ff          <= `TCC_RST_16;
			latch_ff                  <= `TCC_RST_8;
			timer_control_a_ff        <= `TCC_RST_8;
			timer_control_b_ff        <= `TCC_RST_8;
			comparator_control_reg_ff <= `TCC_RST_8;
			timer_irq_mask_reg_ff     <= `TCC_RST_8;
			overflow_flag_ff          <= 1'b0;
			capture_flag_ff           <= 1'b0;
			down_ff                   <= 1'b0;
			trig_prev_ff              <= 1'b0;
			ext_prev_ff               <= 1'b0;
		end else begin
			// count updates independent of tick presence
			count_ff         <= nxt_count;
			capture_value_ff <= nxt_capture;
			latch_ff         <= nxt_latch;
			down_ff          <= nxt_down;
			capture_flag_ff  <= nxt_cap_flag;
			trig_prev_ff     <= trig_sel;
			ext_prev_ff      <= ext_sync;
			// overflow flag set at mode-defined point, set beats clear
			if (nxt_ovf && !cpu_cnt_wr) begin
				overflow_flag_ff <= 1'b1;
			end else if (overflow_ack || (wr_any && reg_addr == `TCC_A_FLAGS && reg_wdata[`TCC_F_OVF])) begin
				overflow_flag_ff <= 1'b0;
			end
			if (wr_any && reg_addr == `TCC_A_CTRL_A) begin
				timer_control_a_ff <= reg_wdata;
			end
			if (wr_any && reg_addr == `TCC_A_CTRL_B) begin
				timer_control_b_ff <= reg_wdata;
			end
			if (wr_any && reg_addr == `TCC_A_MASK) begin
				timer_irq_mask_reg_ff <= reg_wdata;
			end
			// source switch edge left to software to clear
			if (wr_any && reg_addr == `TCC_A_CMP_CTRL) begin
				comparator_control_reg_ff <= reg_wdata;
			end
		end
	end

	// read mux, high locations return latch
	always @* begin
		reg_rdata = 8'h00;
		case (reg_addr)
			`TCC_A_CNT_LO:   reg_rdata = count_ff[7:0];
			`TCC_A_CNT_HI:   reg_rdata = latch_ff;
			`TCC_A_CAP_LO:   reg_rdata = capture_value_ff[7:0];
			`TCC_A_CAP_HI:   reg_rdata = latch_ff;
			`TCC_A_CTRL_A:   reg_rdata = timer_control_a_ff;
			`TCC_A_CTRL_B:   reg_rdata = timer_control_b_ff;
			`TCC_A_FLAGS:    reg_rdata = {2'h0, capture_flag_ff, 4'h0, overflow_flag_ff};
			`TCC_A_MASK:     reg_rdata = timer_irq_mask_reg_ff;
			`TCC_A_CMP_CTRL: reg_rdata = comparator_control_reg_ff;
			default:         reg_rdata = 8'h00;
		endcase
	end

	// interrupt requests gated by mask bits
	assign overflow_irq = overflow_flag_ff && timer_irq_mask_reg_ff[`TCC_F_OVF];
	assign capture_irq  = capture_flag_ff && timer_irq_mask_reg_ff[`TCC_F_CAP];
	assign count_top    = (count_ff == top_val);
	assign count_bottom = (count_ff == `TCC_ZERO);
	assign timer_count  = count_ff;
endmodule
`default_nettype wire

// file: verif/tcc_timer_sva.sv
// assertion checker for the timer counter and capture block
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        overflow_irq,
	input wire logic        capture_irq,
	input wire logic        count_top,
	input wire logic        count_bottom,
	input wire logic [15:0] timer_count
);
	logic [2:0] cs_ff;
	logic [3:0] mode_ff;
	logic [7:0] mask_ff;
	logic       lo_wr;
	logic [7:0] cnt_hi;
	assign lo_wr = reg_wr && reg_addr == 4'h0;
	assign cnt_hi = timer_count[15:8];
	// shadow of clock select, mode and mask as written by software
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_ff <= 3'h0;
			mode_ff <= 4'h0;
			mask_ff <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == 4'h5) begin
				cs_ff <= reg_wdata[2:0];
				mode_ff[3:2] <= reg_wdata[4:3];
			end
			if (reg_addr == 4'h4)
				mode_ff[1:0] <= reg_wdata[1:0];
			if (reg_addr == 4'h7)
				mask_ff <= reg_wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_count_step: assert property (cs_ff == 3'h1 && mode_ff == 4'h0 && !lo_wr
		|=> timer_count == $past(timer_count) + 16'h1) else $error("count did not step by one");
	a_stop_hold: assert property (cs_ff == 3'h0 && !lo_wr |=> $stable(timer_count))
		else $error("count moved while stopped");
	a_write_wins: assert property ((reg_wr && reg_addr == 4'h1) ##1 !(reg_rd || reg_wr) ##1 lo_wr
		|=> timer_count == {$past(reg_wdata, 3), $past(reg_wdata)}) else $error("count write lost");
	a_latch_read: assert property ((reg_rd && reg_addr == 4'h0) ##1 !(reg_rd || reg_wr)
		##1 (reg_rd && reg_addr == 4'h1) |-> reg_rdata == $past(cnt_hi, 2)) else $error("latch wrong");
	a_low_read: assert property (reg_addr == 4'h0 |-> reg_rdata == timer_count[7:0])
		else $error("low byte read wrong");
	a_top_flag: assert property (mode_ff == 4'h0 |-> count_top == (timer_count == 16'hffff))
		else $error("top indication wrong");
	a_bottom_flag: assert property (count_bottom == (timer_count == 16'h0000))
		else $error("bottom indication wrong");
	a_ovf_wrap: assert property (cs_ff == 3'h1 && mode_ff == 4'h0 && mask_ff[0] && !reg_wr
		&& timer_count == 16'hffff |-> ##[1:2] overflow_irq) else $error("overflow not raised");
	a_cap_mask: assert property (capture_irq |-> mask_ff[5])
		else $error("capture request while masked");
endmodule
`default_nettype wire

// file: verif/tcc_event_src.sv
// external event source driving the capture pin and comparator output
`timescale 1ns/100ps
`default_nettype none
module tcc_event_src (
	input  wire logic clk,
	output var  logic capture_pin,
	output var  logic comparator_output
);
	initial begin
		capture_pin = 1'b0;
		comparator_output = 1'b0;
	end
	// change one line after an edge and hold it for a number of cycles
	task automatic drive(input bit sel, input bit lvl, input int hold);
		@(posedge clk);
		if (sel)
			comparator_output <= lvl;
		else
			capture_pin <= lvl;
		repeat (hold) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking testbench for the timer counter and capture block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
	logic        clk, rst, reg_wr, reg_rd, presc_tick, ext_count_pin, overflow_ack, capture_ack;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic        capture_pin, comparator_output, overflow_irq, capture_irq, count_top, count_bottom;
	logic [15:0] timer_count;
	int          bad_count, tests_run;
	tcc_timer u_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .presc_tick,
		.ext_count_pin, .capture_pin, .comparator_output, .overflow_ack, .capture_ack,
		.overflow_irq, .capture_irq, .count_top, .count_bottom, .timer_count);
	tcc_event_src u_src (.clk, .capture_pin, .comparator_output);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(negedge clk);
		`CHK($sformatf("register %h", a), e, reg_rdata)
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	// one cycle acknowledge pulse for the overflow or capture request
	task automatic ack(input bit cap);
		@(posedge clk);
		if (cap)
			capture_ack <= 1'b1;
		else
			overflow_ack <= 1'b1;
		@(posedge clk);
		capture_ack <= 1'b0;
		overflow_ack <= 1'b0;
	endtask
	// one count pin pulse, or one prescaler tick when ext is low; returns after the count settles
	task automatic pulse(input bit ext);
		@(posedge clk);
		if (ext)
			ext_count_pin <= 1'b1;
		else
			presc_tick <= 1'b1;
		@(posedge clk);
		presc_tick <= 1'b0;
		repeat (3) @(posedge clk);
		ext_count_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic wait_irq(input bit cap);
		int n;
		n = 0;
		while ((cap ? capture_irq : overflow_irq) !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		`CHK("request wait", 1'b1, (n < 40))
		if (n >= 40)
			print_verdict();
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, presc_tick, ext_count_pin, overflow_ack, capture_ack} = 6'h00;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// reset values, unmapped address included
		for (int i = 0; i < 10; i++) rd(4'(i), 8'h00);
		`CHK("bottom", 1'b1, count_bottom)
		wr(4'h1, 8'h01);
		wr(4'h0, 8'hff);
		rd(4'h0, 8'hff);
		wr(4'h1, 8'h5a);
		rd(4'h1, 8'h5a);
		rd(4'h0, 8'hff);
		rd(4'h1, 8'h01);
		$display("test count access done");
		// run to wrap, then overwrite while running
		wr(4'h7, 8'h21);
		wr(4'h1, 8'hff);
		wr(4'h0, 8'hf0);
		wr(4'h5, 8'h01);
		wait_irq(1'b0);
		wr(4'h1, 8'h12);
		wr(4'h0, 8'h34);
		wr(4'h5, 8'h40);
		rd(4'h6, 8'h01);
		ack(1'b0);
		rd(4'h6, 8'h00);
		wr(4'h1, 8'h12);
		wr(4'h0, 8'h34);
		repeat (5) @(posedge clk);
		rd(4'h0, 8'h34);
		rd(4'h1, 8'h12);
		$display("test overflow done");
		// rising capture left unread, then falling capture overwrites it
		u_src.drive(1'b0, 1'b1, 1);
		wait_irq(1'b1);
		wr(4'h1, 8'h56);
		wr(4'h0, 8'h78);
		wr(4'h5, 8'h00);
		wr(4'h6, 8'h20);
		rd(4'h6, 8'h00);
		u_src.drive(1'b0, 1'b0, 1);
		wait_irq(1'b1);
		ack(1'b1);
		rd(4'h6, 8'h00);
		rd(4'h2, 8'h78);
		rd(4'h3, 8'h56);
		$display("test pin capture done");
		// comparator as trigger source
		wr(4'h8, 8'h04);
		wr(4'h6, 8'h20);
		wr(4'h1, 8'h0a);
		wr(4'h0, 8'hbc);
		wr(4'h5, 8'h40);
		u_src.drive(1'b0, 1'b1, 16);
		rd(4'h6, 8'h00);
		u_src.drive(1'b1, 1'b1, 1);
		wait_irq(1'b1);
		rd(4'h2, 8'hbc);
		rd(4'h3, 8'h0a);
		wr(4'h8, 8'h00);
		wr(4'h6, 8'h20);
		$display("test comparator done");
		// filtered pin: three cycle pulse rejected, long level kept
		wr(4'h5, 8'hc0);
		u_src.drive(1'b0, 1'b0, 12);
		wr(4'h6, 8'h20);
		u_src.drive(1'b0, 1'b1, 2);
		u_src.drive(1'b0, 1'b0, 16);
		rd(4'h6, 8'h00);
		u_src.drive(1'b0, 1'b1, 1);
		wait_irq(1'b1);
		rd(4'h2, 8'hbc);
		$display("test filter done");
		// capture value as top: writable, trigger ignored
		wr(4'h6, 8'h20);
		wr(4'h5, 8'h58);
		wr(4'h3, 8'h43);
		wr(4'h2, 8'h21);
		rd(4'h2, 8'h21);
		rd(4'h3, 8'h43);
		u_src.drive(1'b0, 1'b0, 6);
		u_src.drive(1'b0, 1'b1, 16);
		rd(4'h6, 8'h00);
		u_src.drive(1'b0, 1'b0, 16);
		wr(4'h5, 8'h40);
		wr(4'h3, 8'h66);
		wr(4'h2, 8'h77);
		rd(4'h2, 8'h21);
		rd(4'h3, 8'h43);
		$display("test capture top done");
		// dual slope turns at top and bottom, on count pin and prescaler ticks
		wr(4'h4, 8'h01);
		wr(4'h5, 8'h47);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'hff);
		@(negedge clk);
		`CHK("top", 1'b1, count_top)
		pulse(1'b1);
		pulse(1'b1);
		rd(4'h0, 8'hfd);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h01);
		pulse(1'b1);
		`CHK("bottom", 1'b1, count_bottom)
		pulse(1'b1);
		rd(4'h6, 8'h01);
		rd(4'h0, 8'h01);
		wr(4'h5, 8'h42);
		pulse(1'b0);
		rd(4'h0, 8'h02);
		wr(4'h5, 8'h46);
		pulse(1'b1);
		rd(4'h0, 8'h03);
		$display("test dual slope done");
		print_verdict();
	end
endmodule
bind tcc_timer tcc_timer_sva u_sva (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.overflow_irq, .capture_irq, .count_top, .count_bottom, .timer_count);
`default_nettype wire
